// *** src/clh_pkg.sv ***
// constants, register map and carriers for the character display host controller
package clh_pkg;
  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SETUP_NS = 60;
  localparam int PULSE_NS = 450;
  localparam int HOLD_NS = 20;
  localparam int NIB_GAP_NS = 1000;
  localparam int EXEC_NS = 50000;
  localparam int INIT_WAIT_NS = 5000000;
  localparam int POWERUP_NS = 15000000;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NIB_GAP_CYC = (NIB_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXEC_CYC = (EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_WAIT_CYC = (INIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_CYC = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 19;
  // ==========================================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08;
  localparam logic [7:0] REG_CURSOR = 8'h0c;
  localparam logic [7:0] REG_LINECLR = 8'h10;
  localparam int CTRL_INIT_BIT = 0;
  localparam int TX_MODE_BIT = 8;
  localparam int CUR_ROW_BIT = 4;
  localparam int CLR_ROW_BIT = 0;
  localparam int ST_INITDONE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_FULL = 2;
  localparam int ST_EMPTY = 3;
  localparam int ST_CLEARING = 4;
  localparam int ST_LEVEL_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // display codes
  localparam logic [7:0] LINE_TOP = 8'h80;
  localparam logic [7:0] LINE_BOT = 8'hc0;
  localparam logic [7:0] SPACE_CHAR = 8'h20;
  localparam logic [4:0] LINE_LEN = 5'h10;
  localparam logic [2:0] INIT_LAST = 3'h7;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_LVL_W = 5;
  // ==========================================================================
  // types
  typedef struct packed {
    logic nibbleOnly;
    logic mode;
    logic [7:0] code;
  } clhItem_s;
  typedef struct packed {
    logic [3:0] upperLines;
    logic modeLine;
    logic strobeLine;
    logic rwSelect;
  } clhPins_s;
  typedef enum logic [2:0] {
    X_IDLE = 3'b000,
    X_SETUP = 3'b001,
    X_PULSE = 3'b010,
    X_HOLD = 3'b011,
    X_GAP = 3'b100,
    X_WAIT = 3'b101
  } clhXfer_e;
endpackage

// *** src/clh_lcd_host.sv ***
// host controller that drives the character display port from AXI4-Lite registers
`timescale 1ns/1ps
module clh_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;

  assign level = wrPtr - rdPtr;
  assign inReady = level != (AW+1)'(DEPTH);
  assign outValid = level != '0;
  assign outData = mem[rdPtr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (inValid && inReady) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (inValid && inReady) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (outValid && outReady) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end
endmodule

module clh_lcd_host import clh_pkg::*; #(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int INIT_WAIT_CYCLES = INIT_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output clhPins_s pins
);
  // ==========================================================================
  // helpers
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return a == REG_CTRL || a == REG_STATUS || a == REG_TXDATA || a == REG_CURSOR || a == REG_LINECLR;
  endfunction

  function automatic clhItem_s initItem(input logic [2:0] step);
    clhItem_s it;
    it.mode = 1'b0;
    it.nibbleOnly = step < 3'h4;
    unique case (step)
      3'h0, 3'h1, 3'h2: it.code = 8'h30;
      3'h3: it.code = 8'h20;
      3'h4: it.code = 8'h28;
      3'h5: it.code = 8'h0e;
      3'h6: it.code = 8'h06;
      3'h7: it.code = 8'h01;
    endcase
    return it;
  endfunction

  // ==========================================================================
  // state
  clhXfer_e xState;
  logic [CNT_W-1:0] cnt;
  clhItem_s cur;
  logic lowPhase;
  logic longWait;
  logic initActive;
  logic initDone;
  logic [2:0] initStep;
  logic clrActive;
  logic [4:0] clrStep;
  logic [7:0] clrCode;
  logic wrTake;
  logic wrGo;
  logic pushAddr;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  clhItem_s fifoOut;
  clhItem_s pushItem;
  logic [FIFO_LVL_W-1:0] fifoLevel;
  clhItem_s item;
  logic itemValid;
  logic take;

  // ==========================================================================
  // AXI4-Lite slave
  assign pushAddr = awaddr == REG_TXDATA || awaddr == REG_CURSOR;
  // a push is held off while the queue is full, so software stalls instead of losing bytes
  assign wrGo = awvalid && wvalid && !awready && !bvalid && (!pushAddr || fifoInReady);
  assign wrTake = awvalid && wvalid && awready && wready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      awready <= wrGo;
      wready <= wrGo;
      if (wrTake) begin
        bvalid <= 1'b1;
        bresp <= isMapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        rdata <= '0;
        if (araddr == REG_STATUS) begin
          rdata[ST_INITDONE] <= initDone;
          rdata[ST_BUSY] <= xState != X_IDLE || initActive || clrActive || fifoOutValid;
          rdata[ST_FULL] <= !fifoInReady;
          rdata[ST_EMPTY] <= !fifoOutValid;
          rdata[ST_CLEARING] <= clrActive;
          rdata[ST_LEVEL_LSB +: FIFO_LVL_W] <= fifoLevel;
        end
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // queue of characters and commands, kept in write order
  always_comb begin
    pushItem.nibbleOnly = 1'b0;
    pushItem.mode = 1'b0;
    pushItem.code = wdata[7:0];
    if (awaddr == REG_TXDATA) begin
      pushItem.mode = wdata[TX_MODE_BIT];
    end else begin
      pushItem.code = (wdata[CUR_ROW_BIT] ? LINE_BOT : LINE_TOP) | {4'h0, wdata[3:0]};
    end
  end

  clh_fifo #(.WIDTH($bits(clhItem_s)), .DEPTH(FIFO_DEPTH)) queue (
    .clk(clk),
    .rst(rst),
    .inValid(wrTake && pushAddr && wstrb[0]),
    .inReady(fifoInReady),
    .inData(pushItem),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOut),
    .level(fifoLevel)
  );

  // ==========================================================================
  // source selection: initialisation, then line clear, then queue
  always_comb begin
    item = initItem(initStep);
    itemValid = 1'b0;
    fifoOutReady = 1'b0;
    if (initActive) begin
      itemValid = 1'b1;
    end else if (clrActive) begin
      itemValid = 1'b1;
      item.nibbleOnly = 1'b0;
      item.mode = clrStep != 5'h0 && clrStep <= LINE_LEN;
      item.code = item.mode ? SPACE_CHAR : clrCode;
    end else if (initDone) begin
      item = fifoOut;
      itemValid = fifoOutValid;
      fifoOutReady = xState == X_IDLE;
    end
  end

  assign take = xState == X_IDLE && itemValid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      initActive <= 1'b1;
      initDone <= 1'b0;
      initStep <= '0;
    end else if (wrTake && awaddr == REG_CTRL && wdata[CTRL_INIT_BIT]) begin
      initActive <= 1'b1;
      initDone <= 1'b0;
      initStep <= '0;
    end else if (take && initActive) begin
      initStep <= initStep + 1'b1;
      if (initStep == INIT_LAST) begin
        initActive <= 1'b0;
        initDone <= 1'b1;
      end
    end
  end

  // a request during a clear is dropped; the running clear finishes first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clrActive <= 1'b0;
      clrStep <= '0;
      clrCode <= LINE_TOP;
    end else if (wrTake && awaddr == REG_LINECLR && !clrActive) begin
      clrActive <= 1'b1;
      clrStep <= '0;
      clrCode <= wdata[CLR_ROW_BIT] ? LINE_BOT : LINE_TOP;
    end else if (take && !initActive && clrActive) begin
      clrStep <= clrStep + 1'b1;
      if (clrStep == LINE_LEN + 5'h1) begin
        clrActive <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // pin sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xState <= X_WAIT;
      cnt <= CNT_W'(POWERUP_CYCLES - 1);
      cur <= '0;
      lowPhase <= 1'b0;
      longWait <= 1'b0;
      pins <= '0;
    end else begin
      pins.rwSelect <= 1'b0;
      unique case (xState)
        X_IDLE: begin
          if (itemValid) begin
            cur <= item;
            lowPhase <= 1'b0;
            longWait <= initActive;
            pins.upperLines <= item.code[7:4];
            pins.modeLine <= item.mode;
            pins.strobeLine <= 1'b0;
            cnt <= CNT_W'(SETUP_CYC - 1);
            xState <= X_SETUP;
          end
        end
        X_SETUP: begin
          if (cnt == '0) begin
            pins.strobeLine <= 1'b1;
            cnt <= CNT_W'(PULSE_CYC - 1);
            xState <= X_PULSE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        X_PULSE: begin
          if (cnt == '0) begin
            pins.strobeLine <= 1'b0;
            cnt <= CNT_W'(HOLD_CYC - 1);
            xState <= X_HOLD;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        X_HOLD: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (!lowPhase && !cur.nibbleOnly) begin
            cnt <= CNT_W'(NIB_GAP_CYC - 1);
            xState <= X_GAP;
          end else begin
            cnt <= longWait ? CNT_W'(INIT_WAIT_CYCLES - 1) : CNT_W'(EXEC_CYC - 1);
            xState <= X_WAIT;
          end
        end
        X_GAP: begin
          if (cnt == '0) begin
            pins.upperLines <= cur.code[3:0];
            lowPhase <= 1'b1;
            cnt <= CNT_W'(SETUP_CYC - 1);
            xState <= X_SETUP;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        X_WAIT: begin
          if (cnt == '0) begin
            xState <= X_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: begin
          xState <= X_IDLE;
        end
      endcase
    end
  end
endmodule

// *** verification/clh_lcd_props.sv ***
// checker for the display host controller port timing
`timescale 1ns/1ps
module clh_lcd_props import clh_pkg::*; #(
  parameter int INIT_WAIT_CYCLES = INIT_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire clhPins_s pins
);
  // short init waits may undercut the nibble gap, so the gap bound takes the smaller
  localparam int MIN_GAP = (NIB_GAP_CYC < INIT_WAIT_CYCLES) ? NIB_GAP_CYC : INIT_WAIT_CYCLES;
  logic [4:0] hiCnt;
  logic [7:0] loCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ====================
  // strobe run lengths
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hiCnt <= 5'h0;
    end else begin
      hiCnt <= pins.strobeLine ? hiCnt + 5'h1 : 5'h0;
    end
  end
  // starts saturated so the first pulse after reset is not judged as a gap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loCnt <= 8'hff;
    end else if (pins.strobeLine) begin
      loCnt <= 8'h0;
    end else if (loCnt != 8'hff) begin
      loCnt <= loCnt + 8'h1;
    end
  end
  // ====================
  // properties
  sequence arTaken;
    arvalid && !arready && !rvalid;
  endsequence
  sequence arAnswer;
    ##1 arready ##1 (rvalid && !arready);
  endsequence
  AST_RW_LOW: assert property (pins.rwSelect == 1'b0)
    else $error("rw select high");
  AST_PULSE_LEN: assert property ($fell(pins.strobeLine) |-> hiCnt == 5'(PULSE_CYC))
    else $error("strobe width wrong");
  AST_DATA_HOLD: assert property ((pins.strobeLine || $past(pins.strobeLine))
    |-> $stable({pins.upperLines, pins.modeLine})) else $error("data moved near strobe");
  AST_SETUP: assert property ($rose(pins.strobeLine)
    |-> {pins.upperLines, pins.modeLine} == $past({pins.upperLines, pins.modeLine}, 2)) else $error("setup short");
  AST_NIB_GAP: assert property ($rose(pins.strobeLine) |-> loCnt >= 8'(MIN_GAP))
    else $error("strobe gap short");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_AR_ANSWER: assert property (arTaken |-> arAnswer)
    else $error("read answer late");
endmodule

bind clh_lcd_host clh_lcd_props #(.INIT_WAIT_CYCLES(INIT_WAIT_CYCLES)) u_props (
  .clk(clk), .rst(rst), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .pins(pins));

// *** verification/clh_lcd_model.sv ***
// behavioural model of the character display behind the nibble port
`timescale 1ns/1ps
module clh_lcd_model import clh_pkg::*; (
  input wire logic rst,
  input wire clhPins_s pins
);
  // write-only port: the model drives nothing back
  logic [8:0] rx[$];
  logic [7:0] mem[0:127];
  logic [6:0] addr = 7'h0;
  logic [3:0] hi;
  int nib = 0;
  // ====================
  // capture on falling strobe; first four nibbles are lone init nibbles
  always @(negedge pins.strobeLine or posedge rst) begin
    if (rst) begin
      nib = 0;
      addr = 7'h0;
      rx.delete();
    end else if (nib < 4) begin
      rx.push_back({pins.modeLine, pins.upperLines, 4'h0});
      nib++;
    end else if (nib % 2 == 0) begin
      hi = pins.upperLines;
      nib++;
    end else begin
      rx.push_back({pins.modeLine, hi, pins.upperLines});
      nib++;
      if (pins.modeLine) begin
        mem[addr] = {hi, pins.upperLines};
        addr++;
      end else if (hi[3]) begin
        addr = {hi[2:0], pins.upperLines};
      end
    end
  end
endmodule

// *** verification/clh_lcd_host_tb.sv ***
// self-checking bench for the display host controller
`timescale 1ns/1ps
module clh_lcd_host_tb import clh_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  clhPins_s pins;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int t0;
  logic [8:0] initExp[9] = '{9'h030, 9'h030, 9'h030, 9'h020, 9'h028, 9'h00e, 9'h006, 9'h001, 9'h141};
  clh_lcd_host #(.POWERUP_CYCLES(20), .INIT_WAIT_CYCLES(10)) dut (.clk(clk), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pins(pins));
  clh_lcd_model u_lcd (.rst(rst), .pins(pins));
  initial begin
    forever #20 clk = ~clk;
  end
  // ====================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // waits for init done, empty queue, no transfer and no clear
  task automatic idle();
    do rd(REG_STATUS); while ((v & 32'h1b) !== 32'h9);
  endtask
  // hang guard sized well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch++;
      close_out();
    end
  end
  // ====================
  // sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(REG_STATUS);
    chk(v & 32'h9, 32'h8);
    wr(REG_TXDATA, 32'h141);
    rd(8'h20);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(v, 32'h0);
    wr(8'h24, 32'h1);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    idle();
    for (int i = 0; i < 9; i++) chk({23'h0, u_lcd.rx[i]}, {23'h0, initExp[i]});
    wr(REG_CURSOR, 32'h13);
    for (int i = 0; i < 16; i++) wr(REG_TXDATA, 32'h161 + i);
    rd(REG_STATUS);
    chk(v & 32'h1f04, 32'h1004);
    t0 = cyc;
    wr(REG_TXDATA, 32'h080);
    chk(32'(cyc - t0 > 500), 32'h1);
    idle();
    chk({23'h0, u_lcd.rx[9]}, 32'h0c3);
    for (int i = 0; i < 16; i++) chk({23'h0, u_lcd.rx[10 + i]}, 32'h161 + i);
    for (int i = 0; i < 16; i++) chk({24'h0, u_lcd.mem[7'h43 + i]}, 32'h61 + i);
    chk({23'h0, u_lcd.rx[26]}, 32'h080);
    wr(REG_LINECLR, 32'h1);
    wr(REG_LINECLR, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(REG_STATUS);
    chk(v & 32'h10, 32'h10);
    idle();
    chk(u_lcd.rx.size(), 45);
    chk({23'h0, u_lcd.rx[27]}, 32'h0c0);
    chk({23'h0, u_lcd.rx[44]}, 32'h0c0);
    for (int i = 0; i < 16; i++) chk({23'h0, u_lcd.rx[28 + i]}, 32'h120);
    for (int i = 0; i < 16; i++) chk({24'h0, u_lcd.mem[7'h40 + i]}, 32'h20);
    chk({24'h0, u_lcd.mem[7'h50]}, 32'h6e);
    // rerun init with a character queued behind it; the model pairs the four lone nibbles
    wr(REG_CTRL, 32'h1);
    wr(REG_TXDATA, 32'h142);
    rd(REG_STATUS);
    chk(v & 32'h1, 32'h0);
    idle();
    chk(u_lcd.rx.size(), 52);
    for (int i = 0; i < 4; i++) chk({23'h0, u_lcd.rx[47 + i]}, {23'h0, initExp[4 + i]});
    chk({23'h0, u_lcd.rx[51]}, 32'h142);
    close_out();
  end
endmodule
